// [bench/mip_core_model.sv]
`timescale 1ns/1ps
module mip_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller side
  input wire mip_pkg::mip_core_out_s core_out,
  output mip_pkg::mip_core_in_s core_in,
  // bench side
  input wire logic gie,
  output logic [7:0] vec_ff
);
  import mip_pkg::*;
  logic ack_d_ff;
  logic busy_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_in <= '0;
      ack_d_ff <= 1'h0;
      busy_ff <= 1'h0;
      vec_ff <= 8'h00;
    end else begin
      core_in.global_ie <= gie;
      core_in.ack <= core_out.maskable_req & !busy_ff;
      ack_d_ff <= core_in.ack;
      if (core_out.maskable_req & !busy_ff) begin
        busy_ff <= 1'h1;
      end else if (!core_out.maskable_req) begin
        busy_ff <= 1'h0;
      end
      // a vector of 10h would go to the default handler
      if (ack_d_ff) begin
        vec_ff <= core_out.ack_vector;
      end
    end
  end
endmodule

// [bench/tb_maskable_irq_status_priority.sv]
`timescale 1ns/1ps
`include "mip_regs.svh"
module tb_maskable_irq_status_priority;
  import mip_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic nmi_req, irq, gie, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] vec;
  mip_lines_t irq_req;
  mip_core_in_s core_in;
  mip_core_out_s core_out;
  int n_fail, samples_checked;

  mip_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .nmi_req(nmi_req), .core_in(core_in),
    .core_out(core_out), .irq(irq));
  mip_core_model core_u (.pclk(pclk), .presetn(presetn),
    .core_out(core_out), .core_in(core_in), .gie(gie), .vec_ff(vec));

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k >= 50) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, nmi_req, gie} = '0;
    paddr = '0;
    pwdata = '0;
    irq_req = '0;
    n_fail = 0;
    samples_checked = 0;
    cyc(16);
    presetn <= 1'h1;
    rchk("ena_lo", `MIP_OFS_ENA_LO, 32'h0000FFFF);
    rchk("ena_hi", `MIP_OFS_ENA_HI, 32'h0000FFFF);
    rchk("vector", `MIP_OFS_VECTOR, 32'h10);
    rchk("act_lo", `MIP_OFS_ACT_LO, 32'h0);
    $display("test reset done");
    for (int i = 1; i < 32; i++) begin
      irq_req <= (32'h2 << i) - 32'h2;
      cyc(3);
      rchk("prio", `MIP_OFS_VECTOR, 32'h10 + i);
    end
    apb(1'h1, `MIP_OFS_ENA_HI, 32'h7FFF);
    irq_req <= 32'h80000020;
    cyc(3);
    rchk("masked_top", `MIP_OFS_VECTOR, 32'h15);
    $display("test priority done");
    irq_req <= 32'hA5A55A5B;
    apb(1'h1, `MIP_OFS_ENA_LO, 32'h0);
    apb(1'h1, `MIP_OFS_ENA_HI, 32'h0);
    cyc(2);
    rchk("act_lo", `MIP_OFS_ACT_LO, 32'h5A5A);
    rchk("act_hi", `MIP_OFS_ACT_HI, 32'hA5A5);
    rchk("all_off", `MIP_OFS_VECTOR, 32'h10);
    apb(1'h1, `MIP_OFS_ACT_LO, 32'hFFFF);
    apb(1'h1, `MIP_OFS_ACT_HI, 32'hFFFF);
    rchk("act_lo_wr", `MIP_OFS_ACT_LO, 32'h5A5A);
    rchk("act_hi_wr", `MIP_OFS_ACT_HI, 32'hA5A5);
    apb(1'h1, `MIP_OFS_ENA_LO, 32'hFFFF);
    apb(1'h1, `MIP_OFS_ENA_HI, 32'hFFFF);
    apb(1'h0, 12'h01C, 32'h0);
    chk("unmapped_err", er, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    $display("test status done");
    irq_req <= '0;
    cyc(3);
    apb(1'h1, `MIP_OFS_EVT_STAT, 32'h3);
    apb(1'h1, `MIP_OFS_EVT_MASK, 32'h1);
    irq_req <= 32'h8;
    cyc(5);
    chk("irq_set", irq, 32'h1);
    rchk("evt", `MIP_OFS_EVT_STAT, 32'h1);
    apb(1'h1, `MIP_OFS_EVT_STAT, 32'h1);
    cyc(2);
    chk("irq_clr", irq, 32'h0);
    irq_req <= '0;
    cyc(3);
    apb(1'h1, `MIP_OFS_EVT_MASK, 32'h0);
    irq_req <= 32'h8;
    cyc(5);
    chk("irq_masked", irq, 32'h0);
    rchk("evt_masked", `MIP_OFS_EVT_STAT, 32'h1);
    $display("test events done");
    chk("no_gie", core_out.maskable_req, 32'h0);
    nmi_req <= 1'h1;
    cyc(1);
    chk("nmi", core_out.nmi_take, 32'h1);
    nmi_req <= 1'h0;
    cyc(1);
    chk("nmi_off", core_out.nmi_take, 32'h0);
    irq_req <= '0;
    cyc(4);
    // line 21 is excluded before the global enable is set
    apb(1'h1, `MIP_OFS_ENA_HI, 32'hFFDF);
    irq_req <= 32'h00300000;
    gie <= 1'h1;
    cyc(12);
    chk("ack_vec", vec, 32'h24);
    $display("test core done");
    irq_req <= '0;
    cyc(4);
    apb(1'h1, `MIP_OFS_EVT_STAT, 32'h3);
    // a one-cycle request is gone again when the core acknowledges it
    irq_req <= 32'h00100000;
    cyc(1);
    irq_req <= '0;
    cyc(6);
    chk("spur_vec", vec, 32'h10);
    rchk("spur_evt", `MIP_OFS_EVT_STAT, 32'h3);
    $display("test empty acknowledge done");
    presetn <= 1'h0;
    cyc(2);
    presetn <= 1'h1;
    rchk("ena_hi_rst", `MIP_OFS_ENA_HI, 32'h0000FFFF);
    rchk("vec_rst", `MIP_OFS_VECTOR, 32'h10);
    $display("test second reset done");
    complete_run();
  end
endmodule

// [hw/mip_ctrl.sv]
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "mip_regs.svh"
// Operation
// [R1] both status words are read-only live request levels; writes ignored
// [R2] low word bits 15..1 show lines 15..1; bit 0 reads zero
// [R3] high word bits 15..0 show lines 31..16; one means active
// [R4] status shows raw requests whatever the enable bits say
// [R5] fixed linear priority among pending lines, line 31 highest
// [R6] lines 31..16 wired to timer, radio, dma, can, audio, uart, voice
// [R7] lines 15..1 wired to bus, timers, spi, uart, wakeup, flash
// [R8] software points reserved vectors at a default handler
// [R9] non-maskable request always passes, nesting with no software action
// [R10] maskable requests are taken only while the global enable is set
// [R11] software clears excluded enables before setting global enable
// [R12] no nesting depth limit inside the controller
// [R13] 31 level requests, lines 1..31, give a vectored interrupt
// [R14] vector is 10h plus highest pending line, 10h when none
// [R15] both enable words reset to all ones
// [R16] status samples request lines on the clock, one edge behind
// [R17] a line is pending only when status and enable are both set
module mip_ctrl
  import mip_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral requests, same clock
  input wire mip_pkg::mip_lines_t irq_req,
  input wire logic nmi_req,
  // processor core
  input wire mip_pkg::mip_core_in_s core_in,
  output mip_pkg::mip_core_out_s core_out,
  // event interrupt
  output logic irq
);
  import mip_pkg::*;

  logic [31:0] src_ff;
  logic [31:0] nxt_src;
  logic [15:0] ena_lo_ff;
  logic [15:0] nxt_ena_lo;
  logic [15:0] ena_hi_ff;
  logic [15:0] nxt_ena_hi;
  logic [1:0] evt_ff;
  logic [1:0] nxt_evt;
  logic [1:0] mask_ff;
  logic [1:0] nxt_mask;
  logic [7:0] vector_ff;
  logic [7:0] nxt_vector;
  logic [7:0] ackv_ff;
  logic [7:0] nxt_ackv;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic err_ff;
  logic nxt_err;
  logic pend_any_ff;
  logic [31:0] pend;
  logic [7:0] vec_comb;
  logic [1:0] evt_set;
  logic [1:0] evt_clr;
  logic setup;
  logic wr_en;

  // request sampling, line 0 forced to zero
  always_comb begin
    nxt_src = irq_req; // [R16] [R4] [R13]
    nxt_src[0] = 1'b0; // [R2]
  end

  // per-line pending and the priority encoder
  always_comb begin
    pend = src_ff & {ena_hi_ff, ena_lo_ff}; // [R17]
    pend[0] = 1'b0;
    vec_comb = `MIP_VEC_BASE; // [R14]
    for (int i = 1; i < 32; i++) begin
      if (pend[i]) begin
        vec_comb = `MIP_VEC_BASE + 8'(i); // [R5] [R14]
      end
    end
  end

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;

  // register writes
  always_comb begin
    nxt_ena_lo = ena_lo_ff;
    nxt_ena_hi = ena_hi_ff;
    nxt_mask = mask_ff;
    evt_clr = 2'h0;
    if (wr_en) begin
      case (paddr)
        `MIP_OFS_ENA_LO: nxt_ena_lo = pwdata[15:0];
        `MIP_OFS_ENA_HI: nxt_ena_hi = pwdata[15:0];
        `MIP_OFS_EVT_MASK: nxt_mask = pwdata[1:0];
        `MIP_OFS_EVT_STAT: evt_clr = pwdata[1:0];
        default: nxt_mask = mask_ff; // [R1]
      endcase
    end
  end

  // events: a line pending when none was pending the cycle before, and an acknowledge that finds nothing
  always_comb begin
    evt_set = 2'h0;
    evt_set[`MIP_EVT_PEND] = (pend != 32'h0) && !pend_any_ff;
    evt_set[`MIP_EVT_SPUR] = core_in.ack && (vector_ff == `MIP_VEC_BASE);
    // set wins over a same-cycle clear
    nxt_evt = (evt_ff & ~evt_clr) | evt_set;
  end

  // read data is captured in the setup cycle
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_err = err_ff;
    if (setup) begin
      nxt_err = 1'b0;
      nxt_prdata = 32'h0;
      case (paddr)
        `MIP_OFS_VECTOR: nxt_prdata = {24'h0, vector_ff};
        `MIP_OFS_ENA_LO: nxt_prdata = {16'h0, ena_lo_ff};
        `MIP_OFS_ENA_HI: nxt_prdata = {16'h0, ena_hi_ff};
        `MIP_OFS_ACT_LO: nxt_prdata = {16'h0, src_ff[15:0]}; // [R2]
        `MIP_OFS_ACT_HI: nxt_prdata = {16'h0, src_ff[31:16]}; // [R3]
        `MIP_OFS_EVT_STAT: nxt_prdata = {30'h0, evt_ff};
        `MIP_OFS_EVT_MASK: nxt_prdata = {30'h0, mask_ff};
        default: nxt_err = 1'b1;
      endcase
    end
  end

  // vector and acknowledge capture
  always_comb begin
    nxt_vector = vec_comb;
    nxt_ackv = ackv_ff;
    if (core_in.ack) begin
      nxt_ackv = vector_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_ff <= 32'h0;
      ena_lo_ff <= `MIP_ENA_RST; // [R15]
      ena_hi_ff <= `MIP_ENA_RST; // [R15]
      evt_ff <= `MIP_EVT_RST;
      mask_ff <= `MIP_MASK_RST;
      vector_ff <= `MIP_VEC_BASE;
      ackv_ff <= `MIP_VEC_BASE;
      prdata_ff <= 32'h0;
      err_ff <= 1'b0;
      pend_any_ff <= 1'b0;
    end else begin
      src_ff <= nxt_src; // [R6] [R7]
      ena_lo_ff <= nxt_ena_lo;
      ena_hi_ff <= nxt_ena_hi;
      evt_ff <= nxt_evt;
      mask_ff <= nxt_mask;
      vector_ff <= nxt_vector;
      ackv_ff <= nxt_ackv;
      prdata_ff <= nxt_prdata;
      err_ff <= nxt_err;
      pend_any_ff <= (pend != 32'h0);
    end
  end

  // no wait state: data is ready in the first access cycle
  assign pready = penable;
  assign prdata = prdata_ff;
  assign pslverr = psel && penable && err_ff;
  assign irq = |(evt_ff & mask_ff);

  // nmi bypasses every mask; maskable waits for the core's global enable
  // and no depth is tracked, so nesting is bounded by the core's stack only
  always_comb begin
    core_out.nmi_take = nmi_req; // [R9]
    core_out.maskable_req = pend_any_ff && core_in.global_ie; // [R10] [R12]
    core_out.ack_vector = ackv_ff;
  end

  sequence s_rd_setup(logic [11:0] ofs);
    psel && !penable && !pwrite && (paddr == ofs);
  endsequence

  sequence s_wr_access(logic [11:0] ofs);
    psel && penable && pwrite && (paddr == ofs);
  endsequence

  AST_BIT0_ZERO: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    s_rd_setup(`MIP_OFS_ACT_LO) |=> prdata[0] == 1'b0 && !pslverr)
    else $error("status bit 0 not zero");

  AST_RD_LO: assert property ( // [R16]
    @(posedge pclk) disable iff (!presetn)
    s_rd_setup(`MIP_OFS_ACT_LO) ##1 $past(presetn, 2)
    |-> prdata[15:1] == $past(irq_req[15:1], 2)
        && prdata[31:16] == 16'h0)
    else $error("low status word not sampled line levels");

  AST_RD_HI: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    s_rd_setup(`MIP_OFS_ACT_HI) ##1 $past(presetn, 2)
    |-> prdata == {16'h0, $past(irq_req[31:16], 2)})
    else $error("high status word wrong");

  AST_RO_WRITE: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    s_wr_access(`MIP_OFS_ACT_HI) |=> src_ff[31:16] == $past(irq_req[31:16])
      && $stable({ena_hi_ff, ena_lo_ff, mask_ff}))
    else $error("write altered status");

  AST_RAW_STATUS: assert property ( // [R17]
    @(posedge pclk) disable iff (!presetn)
    ({ena_hi_ff, ena_lo_ff} == 32'h0) && (src_ff != 32'h0)
    |-> pend == 32'h0 ##1 vector_ff == `MIP_VEC_BASE)
    else $error("disabled source affected vector");

  AST_PEND_AND: assert property ( // [R17]
    @(posedge pclk) disable iff (!presetn)
    (src_ff & ~{ena_hi_ff, ena_lo_ff}) != 32'h0
    |-> (pend & ~{ena_hi_ff, ena_lo_ff}) == 32'h0)
    else $error("disabled line pending");

  AST_VEC_TOP: assert property ( // [R5]
    @(posedge pclk) disable iff (!presetn)
    pend[31] |=> vector_ff == 8'h2F)
    else $error("line 31 not selected");

  AST_VEC_PRIO: assert property ( // [R14]
    @(posedge pclk) disable iff (!presetn)
    (pend != 32'h0) |=>
      ($past(pend) >> (vector_ff - `MIP_VEC_BASE)) == 32'h1)
    else $error("vector not highest pending line");

  AST_NMI: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    nmi_req |-> core_out.nmi_take)
    else $error("nmi blocked");

  AST_GIE: assert property ( // [R10]
    @(posedge pclk) disable iff (!presetn)
    core_out.maskable_req |-> core_in.global_ie && $past(pend != 32'h0))
    else $error("maskable request without global enable");

  AST_ENA_WR: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    s_wr_access(`MIP_OFS_ENA_HI) |=> ena_hi_ff == $past(pwdata[15:0]))
    else $error("enable write lost");

  AST_SPUR_EVT: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_in.ack && vector_ff == `MIP_VEC_BASE
    |=> evt_ff[`MIP_EVT_SPUR] ##0 core_out.ack_vector == `MIP_VEC_BASE)
    else $error("empty acknowledge not flagged");

  AST_IRQ: assert property (
    @(posedge pclk) disable iff (!presetn)
    evt_set[`MIP_EVT_PEND] && mask_ff[`MIP_EVT_PEND]
    && !(wr_en && paddr == `MIP_OFS_EVT_MASK) |=> irq)
    else $error("masked-in event gave no irq");

  AST_STAT_RAW: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    ({ena_hi_ff, ena_lo_ff} != 32'hFFFFFFFF)
    |=> src_ff[31:1] == $past(irq_req[31:1]))
    else $error("status bits gated by enables");

  AST_SRC_BIT0: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    !src_ff[0] && !pend[0])
    else $error("unused line 0 seen as active");

  // read data must stand between transfers
  AST_IDLE_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    !psel |=> $stable(prdata))
    else $error("read data moved while idle");

  AST_UNMAPPED: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && (paddr > `MIP_OFS_EVT_MASK)
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");

  AST_ACK_VEC: assert property ( // [R14]
    @(posedge pclk) disable iff (!presetn)
    core_in.ack |=> core_out.ack_vector == $past(vector_ff))
    else $error("acknowledge vector not captured");

  // set wins over a clear in the same cycle
  AST_EVT_PEND: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pend != 32'h0) && !pend_any_ff |=> evt_ff[`MIP_EVT_PEND])
    else $error("pending event lost");

  AST_MREQ_GIE: assert property ( // [R10]
    @(posedge pclk) disable iff (!presetn)
    pend_any_ff && core_in.global_ie |-> core_out.maskable_req)
    else $error("enabled pending request not raised");

endmodule

// [hw/mip_pkg.sv]
package mip_pkg;
  typedef logic [31:0] mip_lines_t;
  typedef struct packed {
    logic global_ie;
    logic ack;
  } mip_core_in_s;
  typedef struct packed {
    logic maskable_req;
    logic nmi_take;
    logic [7:0] ack_vector;
  } mip_core_out_s;
endpackage

// [hw/mip_regs.svh]
`ifndef MIP_REGS_SVH
`define MIP_REGS_SVH
// register byte offsets
`define MIP_OFS_VECTOR 12'h000
`define MIP_OFS_ENA_LO 12'h004
`define MIP_OFS_ENA_HI 12'h008
`define MIP_OFS_ACT_LO 12'h00C
`define MIP_OFS_ACT_HI 12'h010
`define MIP_OFS_EVT_STAT 12'h014
`define MIP_OFS_EVT_MASK 12'h018
// reset values
`define MIP_ENA_RST 16'hFFFF
`define MIP_EVT_RST 2'h0
`define MIP_MASK_RST 2'h0
`define MIP_VEC_BASE 8'h10
// event bit positions
`define MIP_EVT_PEND 0
`define MIP_EVT_SPUR 1
`endif
